// *** logic/cps_sequencer.sv ***
// dedicated charger cycle sequencer: applies emulation profiles, samples the
// bus-current comparator at timeout, accepts or resets and moves on.
// assumes busCurrentAbove is synchronous to mclk; analog sources sit outside.
`timescale 1ns/100ps
`include "cps_params.svh"
module cps_sequencer
#(
  parameter int TMO_W = 24
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port side
  input wire logic busCurrentAbove,
  output logic portPowerOn,
  output logic vbusDischarge,
  output logic dataPullDown,
  output cps_pkg::cps_stim_t portStim,
  output logic constantCurrentLimit,
  output logic hsSwitchClosed
);
  ////////////////////////////////////////////////////////////////////////////
  // register bus
  logic [31:0] ctrl_q;
  logic [TMO_W-1:0] tmo_q;
  cps_pkg::cps_stim_t cus_q [3];
  logic prep_q;
  logic accepted_q;
  logic dcpDetected_q;
  logic noHandshake_q;
  cps_pkg::cps_state_t state_q;
  cps_pkg::cps_profile_t prof_q;
  wire logic access = psel && penable && !prep_q;
  wire logic commit = psel && penable && prep_q;
  wire logic selCtrl = paddr == `CPS_OFF_CTRL;
  wire logic selTmo = paddr == `CPS_OFF_TMO;
  wire logic selCus0 = paddr == `CPS_OFF_CUS0;
  wire logic selCus1 = paddr == `CPS_OFF_CUS1;
  wire logic selCus2 = paddr == `CPS_OFF_CUS2;
  wire logic selStat = paddr == `CPS_OFF_STAT;
  wire logic mapped = selCtrl | selTmo | selCus0 | selCus1 | selCus2 | selStat;
  wire logic wrCommit = commit && pwrite && mapped;
  wire logic clrFlags = wrCommit && selCtrl && pwdata[`CPS_B_CLRFLG];
  wire logic [31:0] statWord = {20'h00000, constantCurrentLimit, noHandshake_q,
    dcpDetected_q, accepted_q, 1'b0, state_q, prof_q};
  wire logic [31:0] rdMux = selCtrl ? ctrl_q :
    selTmo ? 32'(tmo_q) :
    selCus0 ? 32'(cus_q[0]) :
    selCus1 ? 32'(cus_q[1]) :
    selCus2 ? 32'(cus_q[2]) :
    selStat ? statWord : 32'h00000000;
  // one wait state: the answer is registered so every output comes from a flop
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prep_q <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prep_q <= access;
      pready <= access;
      pslverr <= access && !mapped;
      if (access)
        prdata <= rdMux;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_q <= `CPS_CTRL_RST;
      tmo_q <= TMO_W'(`CPS_TMO_RST);
    end
    else if (wrCommit && selCtrl)
      ctrl_q <= {16'h0000, 1'b0, pwdata[14:0]};
    else if (wrCommit && selTmo)
      tmo_q <= pwdata[TMO_W-1:0];
  end
  // custom stimulus pairs, one word each
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_cus
      wire logic wrCus = wrCommit && paddr == (`CPS_OFF_CUS0 + 12'(gi * 4));
      always_ff @(posedge mclk)
      begin
        if (rst)
          cus_q[gi] <= '0;
        else if (wrCus)
          cus_q[gi] <= pwdata[8:0];
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // control bits and profile table
  wire logic runEn = ctrl_q[`CPS_B_RUN];
  wire logic retryEn = ctrl_q[`CPS_B_RETRY];
  wire logic custFirst = ctrl_q[`CPS_B_CFIRST];
  wire logic keepResp = ctrl_q[`CPS_B_KEEP];
  wire logic minLimitCc = ctrl_q[`CPS_B_MINCC];
  wire logic [8:0] profEn = ctrl_q[`CPS_B_ENHI:`CPS_B_ENLO];
  // slot order of the cycle; custom takes slot 0 or slot 9
  function automatic cps_pkg::cps_profile_t slotProfile(input logic [3:0] s,
    input logic first);
    cps_pkg::cps_profile_t p;
    p = cps_pkg::PR_NONE;
    case (s)
      4'h0: p = first ? cps_pkg::PR_CUST : cps_pkg::PR_NONE;
      4'h1: p = cps_pkg::PR_L1;
      4'h2: p = cps_pkg::PR_DCP;
      4'h3: p = cps_pkg::PR_L2;
      4'h4: p = cps_pkg::PR_L3;
      4'h5: p = cps_pkg::PR_L4;
      4'h6: p = cps_pkg::PR_L5;
      4'h7: p = cps_pkg::PR_L6;
      4'h8: p = cps_pkg::PR_L7;
      4'h9: p = first ? cps_pkg::PR_NONE : cps_pkg::PR_CUST;
      default: p = cps_pkg::PR_NONE;
    endcase
    return p;
  endfunction
  // resident stimuli; analog levels are codes for the source block
  function automatic cps_pkg::cps_stim_t residentStim(
    input cps_pkg::cps_profile_t p);
    cps_pkg::cps_stim_t s;
    s = '0;
    case (p)
      cps_pkg::PR_L1: s = {1'b0, 2'b10, `CPS_LVL_HIGH, 2'b10, `CPS_LVL_HIGH};
      cps_pkg::PR_L3: s = {1'b0, 2'b11, `CPS_LVL_MID, 2'b11, `CPS_LVL_HIGH};
      cps_pkg::PR_L4: s = {1'b0, 2'b11, `CPS_LVL_HIGH, 2'b11, `CPS_LVL_MID};
      cps_pkg::PR_L6: s = {1'b0, 2'b10, `CPS_LVL_LOW, 2'b10, `CPS_LVL_LOW};
      cps_pkg::PR_L5: s = {1'b0, 2'b10, `CPS_LVL_900MV, 2'b10, `CPS_LVL_900MV};
      cps_pkg::PR_L7: s = {1'b0, 2'b11, `CPS_LVL_MID, 4'h0};
      cps_pkg::PR_L2: s = {1'b1, 8'h00};
      cps_pkg::PR_DCP: s = {1'b1, 8'h00};
      cps_pkg::PR_CDP: s = {1'b0, 2'b10, 2'h0, 2'b10, `CPS_LVL_LOW};
      default: s = '0;
    endcase
    return s;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  logic [3:0] step_q;
  logic [1:0] pair_q;
  logic [TMO_W-1:0] cnt_q;
  wire cps_pkg::cps_profile_t slotP = slotProfile(step_q, custFirst);
  wire logic slotOn = slotP != cps_pkg::PR_NONE && profEn[slotP];
  wire logic pastEnd = step_q > `CPS_LAST_STEP;
  wire logic cntZero = cnt_q == '0;
  wire logic isCust = prof_q == cps_pkg::PR_CUST;
  wire logic isShortProf = prof_q == cps_pkg::PR_DCP || prof_q == cps_pkg::PR_L2;
  wire cps_pkg::cps_stim_t nextStim = isCust ? cus_q[pair_q] : residentStim(prof_q);
  // comparator looked at only on the expiry cycle
  wire logic expire = state_q == cps_pkg::ST_WAIT && cntZero;
  wire logic takeIt = expire && busCurrentAbove;
  wire logic morePairs = isCust && pair_q < `CPS_LAST_PAIR;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= cps_pkg::ST_IDLE;
      prof_q <= cps_pkg::PR_NONE;
      step_q <= 4'h0;
      pair_q <= 2'h0;
      cnt_q <= '0;
      portPowerOn <= 1'b0;
      vbusDischarge <= 1'b0;
      dataPullDown <= 1'b0;
      portStim <= '0;
      constantCurrentLimit <= 1'b0;
      hsSwitchClosed <= 1'b0;
    end
    else if (!runEn)
    begin
      state_q <= cps_pkg::ST_IDLE;
      prof_q <= cps_pkg::PR_NONE;
      step_q <= 4'h0;
      portPowerOn <= 1'b0;
      vbusDischarge <= 1'b0;
      dataPullDown <= 1'b0;
      portStim <= '0;
      constantCurrentLimit <= 1'b0;
      hsSwitchClosed <= 1'b1;
    end
    else
    begin
      hsSwitchClosed <= 1'b0;
      case (state_q)
        cps_pkg::ST_IDLE:
        begin
          step_q <= 4'h0;
          state_q <= cps_pkg::ST_SELECT;
        end
        cps_pkg::ST_SELECT:
        begin
          if (pastEnd && retryEn)
            step_q <= 4'h0;
          else if (pastEnd)
          begin
            state_q <= cps_pkg::ST_DONE;
            prof_q <= cps_pkg::PR_NONE;
            portStim <= '0;
            dataPullDown <= 1'b0;
            portPowerOn <= 1'b1;
            constantCurrentLimit <= minLimitCc;
          end
          else if (slotOn)
          begin
            prof_q <= slotP;
            pair_q <= 2'h0;
            cnt_q <= TMO_W'(`CPS_DISCH_CYC - 1);
            state_q <= cps_pkg::ST_DISCH;
            portPowerOn <= 1'b0;
            vbusDischarge <= 1'b1;
            dataPullDown <= 1'b1;
            portStim <= '0;
          end
          else
            step_q <= step_q + 4'h1;
        end
        cps_pkg::ST_DISCH:
        begin
          cnt_q <= cnt_q - 1'b1;
          if (cntZero)
          begin
            vbusDischarge <= 1'b0;
            cnt_q <= TMO_W'(`CPS_RESET_CYC - 1);
            state_q <= cps_pkg::ST_HOLD;
          end
        end
        cps_pkg::ST_HOLD:
        begin
          cnt_q <= cnt_q - 1'b1;
          if (cntZero)
            state_q <= cps_pkg::ST_STIM;
        end
        cps_pkg::ST_STIM:
        begin
          // stimulus lands a full cycle before the switch closes
          dataPullDown <= 1'b0;
          portStim <= nextStim;
          state_q <= cps_pkg::ST_POWER;
        end
        cps_pkg::ST_POWER:
        begin
          portPowerOn <= 1'b1;
          constantCurrentLimit <= 1'b1;
          cnt_q <= tmo_q;
          state_q <= cps_pkg::ST_WAIT;
        end
        cps_pkg::ST_WAIT:
        begin
          cnt_q <= cnt_q - 1'b1;
          if (takeIt && morePairs)
          begin
            pair_q <= pair_q + 2'h1;
            portStim <= cus_q[pair_q + 2'h1];
            cnt_q <= tmo_q;
          end
          else if (takeIt)
          begin
            state_q <= cps_pkg::ST_DONE;
            // short stays for dedicated-port and legacy 2
            if (!isShortProf && !keepResp)
              portStim <= '0;
            constantCurrentLimit <= isShortProf ? 1'b1 : minLimitCc;
          end
          else if (expire)
          begin
            portStim <= '0;
            step_q <= step_q + 4'h1;
            state_q <= cps_pkg::ST_SELECT;
          end
        end
        cps_pkg::ST_DONE:
          state_q <= cps_pkg::ST_DONE;
        default:
          state_q <= cps_pkg::ST_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // status flags: hardware set wins over software clear
  wire logic setAcc = runEn && takeIt && !morePairs;
  wire logic setDcp = setAcc && prof_q == cps_pkg::PR_DCP;
  wire logic setNoHs = runEn && state_q == cps_pkg::ST_SELECT && pastEnd && !retryEn;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      accepted_q <= 1'b0;
      dcpDetected_q <= 1'b0;
      noHandshake_q <= 1'b0;
    end
    else
    begin
      accepted_q <= setAcc | (accepted_q & !clrFlags);
      dcpDetected_q <= setDcp | (dcpDetected_q & !clrFlags);
      noHandshake_q <= setNoHs | (noHandshake_q & !clrFlags);
    end
  end
endmodule // cps_sequencer

// *** logic/cps_params.svh ***
// named offsets, field positions, reset values and timing for the
// charger profile sequencer; assumes a 10 MHz mclk
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH
`define CPS_CLK_MHZ 10
`define CPS_T_DISCH_US 100
`define CPS_T_RESET_US 200
`define CPS_DISCH_CYC (`CPS_T_DISCH_US * `CPS_CLK_MHZ)
`define CPS_RESET_CYC (`CPS_T_RESET_US * `CPS_CLK_MHZ)
`define CPS_TMO_RST 24'h0F4240
`define CPS_OFF_CTRL 12'h000
`define CPS_OFF_TMO 12'h004
`define CPS_OFF_CUS0 12'h008
`define CPS_OFF_CUS1 12'h00C
`define CPS_OFF_CUS2 12'h010
`define CPS_OFF_STAT 12'h014
`define CPS_CTRL_RST 32'h00001FEA
`define CPS_B_RUN 0
`define CPS_B_RETRY 1
`define CPS_B_CFIRST 2
`define CPS_B_KEEP 3
`define CPS_B_MINCC 4
`define CPS_B_ENLO 5
`define CPS_B_ENHI 13
`define CPS_B_CLRFLG 15
`define CPS_LAST_STEP 4'h9
`define CPS_LAST_PAIR 2'h2
`define CPS_LVL_LOW 2'h1
`define CPS_LVL_MID 2'h2
`define CPS_LVL_HIGH 2'h3
`define CPS_LVL_900MV 2'h0
`endif

// *** logic/cps_pkg.sv ***
// types shared by the charger profile sequencer
// assumes cps_params.svh supplies the numeric constants
package cps_pkg;
  typedef enum logic [3:0]
  {
    PR_L1 = 4'h0, PR_L2 = 4'h1, PR_L3 = 4'h2, PR_L4 = 4'h3, PR_L5 = 4'h4,
    PR_L6 = 4'h5, PR_L7 = 4'h6, PR_DCP = 4'h7, PR_CUST = 4'h8,
    PR_CDP = 4'h9, PR_NONE = 4'hF
  } cps_profile_t;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000, ST_SELECT = 3'b001, ST_DISCH = 3'b010, ST_HOLD = 3'b011,
    ST_STIM = 3'b100, ST_POWER = 3'b101, ST_WAIT = 3'b110, ST_DONE = 3'b111
  } cps_state_t;
  typedef struct packed
  {
    logic en;
    logic divider;
    logic [1:0] level;
  } cps_line_t;
  typedef struct packed
  {
    logic shortRes;
    cps_line_t dataPlus;
    cps_line_t dataMinus;
  } cps_stim_t;
endpackage

// *** sim/cps_sequencer_monitor.sv ***
// checker for port phasing and bus timing of the sequencer
// assumes cps_pkg is compiled first
`timescale 1ns/100ps
`include "cps_params.svh"
module cps_sequencer_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // port side
  input wire logic portPowerOn,
  input wire logic vbusDischarge,
  input wire logic dataPullDown,
  input wire cps_pkg::cps_stim_t portStim,
  input wire logic hsSwitchClosed
);
  logic [11:0] disCnt_q;
  logic [11:0] holdCnt_q;
  ////////////////////////////////////////
  // phase lengths; a reset mid-phase restarts the count
  always_ff @(posedge mclk)
  begin
    disCnt_q <= (rst || !vbusDischarge) ? 12'h000 : disCnt_q + 12'h001;
    holdCnt_q <= (rst || vbusDischarge || !dataPullDown) ? 12'h000 : holdCnt_q + 12'h001;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  AST_APB_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("apb answer off its wait state");
  AST_DISCH_OFF: assert property (vbusDischarge |-> !portPowerOn && dataPullDown)
    else $error("discharge with power on");
  // a run-bit drop cuts the phase short and closes the switch, so it is left out
  AST_DISCH_LEN: assert property ($fell(vbusDischarge) && !hsSwitchClosed |->
    disCnt_q == `CPS_DISCH_CYC) else $error("discharge length wrong");
  // pull-down spans the hold plus the one stimulus cycle after it
  AST_HOLD_LEN: assert property ($fell(dataPullDown) && !hsSwitchClosed |->
    holdCnt_q == `CPS_RESET_CYC + 1) else $error("reset hold length wrong");
  AST_PULL_CLEAN: assert property (dataPullDown |-> portStim == 9'h000)
    else $error("stimulus during pull-down");
  AST_STIM_FIRST: assert property ($rose(portPowerOn) && portStim != 9'h000 |->
    $past(portStim) == portStim && !$past(dataPullDown)) else $error("power before stimulus");
  AST_REJ_RESET: assert property ($fell(portPowerOn) && !hsSwitchClosed |->
    ##[0:12] vbusDischarge) else $error("no emulation reset after power drop");
  AST_SHORT_HS: assert property (portStim.shortRes |-> !hsSwitchClosed)
    else $error("short with switch closed");
endmodule // cps_sequencer_monitor
bind cps_sequencer cps_sequencer_monitor i_cps_sequencer_monitor (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .portPowerOn(portPowerOn), .vbusDischarge(vbusDischarge), .dataPullDown(dataPullDown),
  .portStim(portStim), .hsSwitchClosed(hsSwitchClosed));

// *** sim/cps_portable_model.sv ***
// portable device drawing charge on one chosen profile application
// assumes the sequencer idles with the high-speed switch closed
`timescale 1ns/100ps
module cps_portable_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // port side
  input wire logic portPowerOn,
  input wire logic hsSwitchClosed,
  input wire logic [3:0] acceptAt,
  output logic busCurrentAbove
);
  logic [3:0] appCnt_q;
  logic powPrev_q;
  ////////////////////////////////////////
  // unpowered device draws nothing; 0 means never accept
  assign busCurrentAbove = portPowerOn && acceptAt != 4'h0 && appCnt_q == acceptAt;
  always_ff @(posedge mclk)
  begin
    powPrev_q <= portPowerOn;
    if (rst || hsSwitchClosed)
      appCnt_q <= 4'h0;
    else if (portPowerOn && !powPrev_q)
      appCnt_q <= appCnt_q + 4'h1;
  end
endmodule // cps_portable_model

// *** sim/cps_sequencer_tb.sv ***
// bench: apb tasks and charger cycle scenarios
// assumes the portable model and bound checker are compiled
`timescale 1ns/100ps
`include "cps_params.svh"
module cps_sequencer_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] acceptAt = 4'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, busCurrentAbove, portPowerOn, vbusDischarge, dataPullDown;
  logic constantCurrentLimit, hsSwitchClosed, err, powPrev;
  cps_pkg::cps_stim_t portStim;
  cps_pkg::cps_stim_t stimLog [16];
  int logCnt = 0;
  int mismatches = 0;
  int totalChecks = 0;
  ////////////////////////////////////////
  always #50 mclk = ~mclk;
  cps_sequencer i_cps_sequencer (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busCurrentAbove(busCurrentAbove), .portPowerOn(portPowerOn),
    .vbusDischarge(vbusDischarge), .dataPullDown(dataPullDown), .portStim(portStim),
    .constantCurrentLimit(constantCurrentLimit), .hsSwitchClosed(hsSwitchClosed));
  cps_portable_model i_cps_portable_model (
    .mclk(mclk), .rst(rst), .portPowerOn(portPowerOn), .hsSwitchClosed(hsSwitchClosed),
    .acceptAt(acceptAt), .busCurrentAbove(busCurrentAbove));
  // stimulus standing at each power-up, in order
  always @(posedge mclk)
  begin
    powPrev <= portPowerOn;
    // switch closed means run is low: the log restarts with every run
    if (hsSwitchClosed)
      logCnt <= 0;
    else if (portPowerOn && !powPrev && logCnt < 16)
    begin
      stimLog[logCnt] <= portStim;
      logCnt <= logCnt + 1;
    end
  end
  task close_out;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one transfer; an idle cycle after it keeps psel from toggling twice
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    if (n >= 20)
    begin
      mismatches++;
      close_out;
    end
  endtask
  // poll status; bound covers a full cycle of all profiles
  task waitFlag(input logic [31:0] mask);
    int k;
    k = 0;
    do
    begin
      xfer(`CPS_OFF_STAT, 1'b0, 32'h00000000);
      k++;
    end
    while ((rd & mask) == 32'h00000000 && k < 15000);
    if ((rd & mask) == 32'h00000000)
    begin
      mismatches++;
      close_out;
    end
  endtask
  task start(input logic [31:0] cfg, input logic [3:0] acc);
    xfer(`CPS_OFF_CTRL, 1'b1, cfg | 32'h00008000);
    acceptAt <= acc;
    xfer(`CPS_OFF_CTRL, 1'b1, cfg | 32'h00000001);
    waitFlag(acc == 4'h0 ? 32'h00000400 : 32'h00000100);
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    chk({portPowerOn, vbusDischarge, dataPullDown, portStim}, 32'h00000000);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(hsSwitchClosed, 32'h00000001);
    xfer(`CPS_OFF_CTRL, 1'b0, 32'h00000000);
    chk(rd, `CPS_CTRL_RST);
    xfer(`CPS_OFF_TMO, 1'b0, 32'h00000000);
    chk(rd, `CPS_TMO_RST);
    xfer(12'h018, 1'b1, 32'hFFFFFFFF);
    chk(err, 32'h00000001);
    xfer(12'h018, 1'b0, 32'h00000000);
    chk({err, rd[30:0]}, 32'h80000000);
    xfer(`CPS_OFF_TMO, 1'b1, 32'h00000014);
    start(32'h00001FE8, 4'h3);
    chk(rd[3:0], cps_pkg::PR_L2);
    chk({portStim.shortRes, constantCurrentLimit, hsSwitchClosed}, 32'h00000006);
    start(32'h00001FE8, 4'h2);
    chk(rd[9], 32'h00000001);
    chk({portStim.shortRes, constantCurrentLimit, hsSwitchClosed}, 32'h00000006);
    // keep-response and min-limit off: lines freed, trip limiting
    start(32'h00001FE0, 4'h8);
    chk(rd[3:0], cps_pkg::PR_L7);
    chk({portStim, constantCurrentLimit}, 32'h00000000);
    chk(logCnt, 32'h00000008);
    chk({stimLog[1].shortRes, stimLog[2].shortRes}, 32'h00000003);
    chk({stimLog[0].dataPlus.en, stimLog[0].dataMinus.en}, 32'h00000003);
    chk({stimLog[5].dataPlus.en, stimLog[5].dataPlus.level, stimLog[5].dataMinus.en,
      stimLog[5].dataMinus.level}, {26'h0, 1'b1, `CPS_LVL_900MV, 1'b1, `CPS_LVL_900MV});
    chk({stimLog[7].dataPlus.en, stimLog[7].dataPlus.divider, stimLog[7].dataMinus.en},
      32'h00000006);
    start(32'h00001FF8, 4'h1);
    chk(portStim, stimLog[0]);
    chk(constantCurrentLimit, 32'h00000001);
    xfer(`CPS_OFF_CUS0, 1'b1, 32'h000000A5);
    xfer(`CPS_OFF_CUS1, 1'b1, 32'h0000014B);
    xfer(`CPS_OFF_CUS2, 1'b1, 32'h000000D2);
    start(32'h00003FEC, 4'h1);
    chk(rd[3:0], cps_pkg::PR_CUST);
    chk(stimLog[0], 32'h000000A5);
    chk(portStim, 32'h000000D2);
    // custom alone, placed last: every legacy slot is skipped first
    start(32'h00002008, 4'h1);
    chk({rd[3:0], logCnt[3:0]}, {24'h0, cps_pkg::PR_CUST, 4'h1});
    // only the first legacy profile enabled keeps each pass short
    start(32'h00000022, 4'h2);
    chk({rd[3:0], logCnt[3:0]}, {24'h0, cps_pkg::PR_L1, 4'h2});
    start(32'h00000020, 4'h0);
    chk({portPowerOn, portStim}, 32'h00000200);
    close_out;
  end
endmodule // cps_sequencer_tb
